// ==== common/tcw_pkg.sv ====
// Package for the timer compare/waveform unit: register map, field layout,
// mode and action codes, and the pin carrier type.
// Assumes one 25 MHz clock domain and a Wishbone classic register bus.
package tcw_pkg;
  // Register byte offsets
  localparam logic [7:0] TCW_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCW_OFF_FORCE = 8'h04;
  localparam logic [7:0] TCW_OFF_COUNT = 8'h08;
  localparam logic [7:0] TCW_OFF_CMPA = 8'h0c;
  localparam logic [7:0] TCW_OFF_CMPB = 8'h10;
  localparam logic [7:0] TCW_OFF_FLAGS = 8'h14;
  localparam logic [7:0] TCW_OFF_PORT = 8'h18;
  // Control field positions
  localparam int TCW_CTRL_WGM_LSB = 0;
  localparam int TCW_CTRL_COMA_LSB = 4;
  localparam int TCW_CTRL_COMB_LSB = 6;
  // Flag and port bit positions
  localparam int TCW_FLG_OVF = 0;
  localparam int TCW_FLG_CFA = 1;
  localparam int TCW_FLG_CFB = 2;
  localparam int TCW_PORT_DATA_A = 0;
  localparam int TCW_PORT_DATA_B = 1;
  localparam int TCW_PORT_DIR_A = 2;
  localparam int TCW_PORT_DIR_B = 3;
  // Waveform modes
  localparam logic [2:0] TCW_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TCW_WGM_CTC = 3'h2;
  localparam logic [2:0] TCW_WGM_FPWM_MAX = 3'h3;
  localparam logic [2:0] TCW_WGM_FPWM_CMPA = 3'h7;
  // Output actions
  localparam logic [1:0] TCW_COM_NONE = 2'h0;
  localparam logic [1:0] TCW_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TCW_COM_CLEAR = 2'h2;
  localparam logic [1:0] TCW_COM_SET = 2'h3;
  // Counter limits and reset values
  localparam logic [7:0] TCW_MAX = 8'hff;
  localparam logic [7:0] TCW_BOTTOM = 8'h00;
  localparam logic [7:0] TCW_RST_BYTE = 8'h00;

  typedef struct packed {
    logic val;
    logic oe;
  } tcw_pin_t;
endpackage

// ==== verilog/tcw_unit.sv ====
// Compare-match waveform unit of an 8-bit timer with Wishbone classic registers.
// Assumes tick_i is a one-cycle timer-clock enable from a prescaler on clk_i.

// Behaviour
// - Nonzero action field routes compare output to pin
// - Pin direction still follows port direction bit
// - Override works in every waveform mode
// - Action zero leaves compare output unchanged
// - New action field applies at next match
// - Force strobe applies action now, non-PWM
// - Mode sets counting; action sets output only
// - Mode 0 counts up, wraps FF to 00
// - Normal mode overflow flag set at zero
// - Mode 2 clears counter on compare A
// - Clear-on-match sets flag A each period
// - Unbuffered compare A may miss, wraps first
// - Action 1 toggles output A per match
// - Toggle period is one plus compare A
// - Clear-on-match overflow flag at max-to-zero
// - Modes 3 and 7 count zero to top
// - Fast PWM clears the cycle after top
// - Action 2 clears on match, sets at bottom
// - Fast PWM overflow flag set at top
// - Compare zero spikes; compare max constant
// - Fast PWM action 1 toggles, buffered compare
// - PWM buffers compare values, others bypass
// - Compare flag set next tick; write one clears
// - Force changes output only, no flag or counter
// - Counter write blocks matches next tick
module tcw_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output tcw_pkg::tcw_pin_t pin_a_o,
  output tcw_pkg::tcw_pin_t pin_b_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] wgm;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic oc_a;
    logic oc_b;
    logic ovf;
    logic cf_a;
    logic cf_b;
    logic pend_a;
    logic pend_b;
    logic block;
    logic [7:0] gap;
    logic gap_ok;
    logic [3:0] port;
    logic ack;
    logic [31:0] dat;
    tcw_pkg::tcw_pin_t pin_a;
    tcw_pkg::tcw_pin_t pin_b;
  } tcw_state_t;

  tcw_state_t st_ff;
  tcw_state_t nxt_st;
  logic bus_req;
  logic wr;
  logic cnt_wr;
  logic pwm;
  logic [7:0] top;
  logic at_top;
  logic match_a;
  logic match_b;
  logic [7:0] wbyte;

  function automatic logic act(input logic [1:0] com, input logic oc);
    case (com)
      tcw_pkg::TCW_COM_TOGGLE: act = ~oc;
      tcw_pkg::TCW_COM_CLEAR: act = 1'b0;
      tcw_pkg::TCW_COM_SET: act = 1'b1;
      default: act = oc;
    endcase
  endfunction

  always_comb begin
    nxt_st = st_ff;
    bus_req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    wr = bus_req & wb_we_i & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    cnt_wr = wr && (wb_adr_i == tcw_pkg::TCW_OFF_COUNT);
    // The mode field picks the count sequence; compare A gives top in mode 7
    pwm = (st_ff.wgm == tcw_pkg::TCW_WGM_FPWM_MAX) || (st_ff.wgm == tcw_pkg::TCW_WGM_FPWM_CMPA);
    top = (st_ff.wgm == tcw_pkg::TCW_WGM_FPWM_CMPA) ? st_ff.cmp_a : tcw_pkg::TCW_MAX;
    at_top = st_ff.cnt == top;
    match_a = (st_ff.cnt == st_ff.cmp_a) && ~st_ff.block;
    match_b = (st_ff.cnt == st_ff.cmp_b) && ~st_ff.block;

    nxt_st.ack = bus_req;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        tcw_pkg::TCW_OFF_CTRL: nxt_st.dat = {24'h0, st_ff.com_b, st_ff.com_a, 1'b0, st_ff.wgm};
        tcw_pkg::TCW_OFF_COUNT: nxt_st.dat = {24'h0, st_ff.cnt};
        tcw_pkg::TCW_OFF_CMPA: nxt_st.dat = {24'h0, st_ff.buf_a};
        tcw_pkg::TCW_OFF_CMPB: nxt_st.dat = {24'h0, st_ff.buf_b};
        tcw_pkg::TCW_OFF_FLAGS: nxt_st.dat = {29'h0, st_ff.cf_b, st_ff.cf_a, st_ff.ovf};
        tcw_pkg::TCW_OFF_PORT: nxt_st.dat = {28'h0, st_ff.port};
        default: nxt_st.dat = 32'h0;
      endcase
    end

    // Write-one-to-clear first, so a same-cycle hardware set wins
    if (wr && (wb_adr_i == tcw_pkg::TCW_OFF_FLAGS)) begin
      if (wbyte[tcw_pkg::TCW_FLG_OVF]) nxt_st.ovf = 1'b0;
      if (wbyte[tcw_pkg::TCW_FLG_CFA]) nxt_st.cf_a = 1'b0;
      if (wbyte[tcw_pkg::TCW_FLG_CFB]) nxt_st.cf_b = 1'b0;
    end

    if (tick_i) begin
      nxt_st.block = 1'b0;
      // Flag trails the match by one timer clock
      nxt_st.pend_a = match_a;
      nxt_st.pend_b = match_b;
      if (st_ff.pend_a) nxt_st.cf_a = 1'b1;
      if (st_ff.pend_b) nxt_st.cf_b = 1'b1;
      if (pwm) begin
        if (at_top) begin
          nxt_st.cnt = tcw_pkg::TCW_BOTTOM;
          nxt_st.ovf = 1'b1;
          nxt_st.cmp_a = st_ff.buf_a;
          nxt_st.cmp_b = st_ff.buf_b;
        end else begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
        end
      end else begin
        if ((st_ff.wgm == tcw_pkg::TCW_WGM_CTC) && match_a) begin
          nxt_st.cnt = tcw_pkg::TCW_BOTTOM;
        end else begin
          // A missed compare A simply rolls on through max
          nxt_st.cnt = st_ff.cnt + 8'h01;
        end
        if (st_ff.cnt == tcw_pkg::TCW_MAX) nxt_st.ovf = 1'b1;
      end
      // Action field read at the match itself, so a new value waits for one
      if (match_a) nxt_st.oc_a = act(st_ff.com_a, st_ff.oc_a);
      if (match_b) nxt_st.oc_b = act(st_ff.com_b, st_ff.oc_b);
      // Bottom restart wins over a match at top, giving the constant level
      if (pwm && at_top && st_ff.com_a[1]) nxt_st.oc_a = ~st_ff.com_a[0];
      if (pwm && at_top && st_ff.com_b[1]) nxt_st.oc_b = ~st_ff.com_b[0];
    end

    if (wr) begin
      case (wb_adr_i)
        tcw_pkg::TCW_OFF_CTRL: begin
          nxt_st.wgm = wbyte[tcw_pkg::TCW_CTRL_WGM_LSB +: 3];
          nxt_st.com_a = wbyte[tcw_pkg::TCW_CTRL_COMA_LSB +: 2];
          nxt_st.com_b = wbyte[tcw_pkg::TCW_CTRL_COMB_LSB +: 2];
        end
        tcw_pkg::TCW_OFF_FORCE: begin
          // Force never touches the flags or the counter
          if (!pwm && wbyte[0]) nxt_st.oc_a = act(st_ff.com_a, st_ff.oc_a);
          if (!pwm && wbyte[1]) nxt_st.oc_b = act(st_ff.com_b, st_ff.oc_b);
        end
        tcw_pkg::TCW_OFF_COUNT: begin
          // Processor write outranks count and clear
          nxt_st.cnt = wbyte;
          nxt_st.block = 1'b1;
        end
        tcw_pkg::TCW_OFF_CMPA: begin
          nxt_st.buf_a = wbyte;
          if (!pwm) nxt_st.cmp_a = wbyte;
        end
        tcw_pkg::TCW_OFF_CMPB: begin
          nxt_st.buf_b = wbyte;
          if (!pwm) nxt_st.cmp_b = wbyte;
        end
        tcw_pkg::TCW_OFF_PORT: nxt_st.port = wbyte[3:0];
        default: nxt_st.port = nxt_st.port;
      endcase
    end

    // Ticks since the last clear-on-match reload; any bus write spoils the measure
    if (wr) begin
      nxt_st.gap_ok = 1'b0;
    end else if (tick_i && match_a) begin
      nxt_st.gap = tcw_pkg::TCW_BOTTOM;
      nxt_st.gap_ok = (st_ff.wgm == tcw_pkg::TCW_WGM_CTC);
    end else if (tick_i) begin
      nxt_st.gap = st_ff.gap + 8'h01;
    end

    // Override is mode independent; direction stays with the port
    nxt_st.pin_a.val = (nxt_st.com_a != tcw_pkg::TCW_COM_NONE) ? nxt_st.oc_a
                       : nxt_st.port[tcw_pkg::TCW_PORT_DATA_A];
    nxt_st.pin_b.val = (nxt_st.com_b != tcw_pkg::TCW_COM_NONE) ? nxt_st.oc_b
                       : nxt_st.port[tcw_pkg::TCW_PORT_DATA_B];
    nxt_st.pin_a.oe = nxt_st.port[tcw_pkg::TCW_PORT_DIR_A];
    nxt_st.pin_b.oe = nxt_st.port[tcw_pkg::TCW_PORT_DIR_B];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.dat;
  assign wb_ack_o = st_ff.ack;
  assign pin_a_o = st_ff.pin_a;
  assign pin_b_o = st_ff.pin_b;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_OVERRIDE_A: assert property (
    (st_ff.com_a != tcw_pkg::TCW_COM_NONE) |-> (pin_a_o.val == st_ff.oc_a))
    else $error("pin A not driven by compare output");
  AST_DIR_A: assert property (
    pin_a_o.oe == st_ff.port[tcw_pkg::TCW_PORT_DIR_A])
    else $error("pin A direction not from port");
  AST_HOLD_A: assert property (
    (tick_i && !wr && st_ff.com_a == tcw_pkg::TCW_COM_NONE) |=> $stable(st_ff.oc_a))
    else $error("compare output A changed with action zero");
  AST_NORMAL_WRAP: assert property (
    (tick_i && !wr && st_ff.wgm == tcw_pkg::TCW_WGM_NORMAL && st_ff.cnt == 8'hff)
    |=> (st_ff.cnt == 8'h00 && st_ff.ovf))
    else $error("normal mode wrap or overflow wrong");
  AST_CTC_CLEAR: assert property (
    (tick_i && !wr && st_ff.wgm == tcw_pkg::TCW_WGM_CTC && match_a) |=> st_ff.cnt == 8'h00)
    else $error("clear-on-match did not clear");
  AST_PEND_A: assert property (
    (tick_i && match_a) |=> st_ff.pend_a)
    else $error("compare A match not recorded");
  AST_FLAG_A: assert property (
    (tick_i && st_ff.pend_a) |=> st_ff.cf_a)
    else $error("compare flag A not set after match");
  AST_PEND_B: assert property (
    (tick_i && match_b) |=> st_ff.pend_b)
    else $error("compare B match not recorded");
  AST_FLAG_B: assert property (
    (tick_i && st_ff.pend_b) |=> st_ff.cf_b)
    else $error("compare flag B not set after match");
  AST_FLAG_CLEAR: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_FLAGS && wbyte[tcw_pkg::TCW_FLG_CFA]
      && !(tick_i && st_ff.pend_a)) |=> !st_ff.cf_a)
    else $error("compare flag A not cleared by write one");
  AST_BLOCK_SET: assert property (
    cnt_wr |=> st_ff.block)
    else $error("counter write did not arm match blocking");
  AST_BLOCK: assert property (
    (tick_i && st_ff.block) |=> (!st_ff.pend_a && !st_ff.pend_b))
    else $error("match not blocked after counter write");
  AST_FPWM_TOP: assert property (
    (tick_i && !wr && pwm && at_top) |=> (st_ff.cnt == 8'h00 && st_ff.ovf))
    else $error("fast PWM restart or overflow wrong");
  AST_FPWM_SET: assert property (
    (tick_i && !wr && pwm && at_top && st_ff.com_a == tcw_pkg::TCW_COM_CLEAR) |=> st_ff.oc_a)
    else $error("fast PWM output not set at bottom");
  AST_FORCE: assert property (
    (wr && !tick_i && wb_adr_i == tcw_pkg::TCW_OFF_FORCE)
    |=> ($stable(st_ff.cnt) && $stable(st_ff.cf_a) && $stable(st_ff.cf_b)))
    else $error("force disturbed counter or flags");
  AST_BUS_ACK: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");

  AST_OVERRIDE_B: assert property (
    (st_ff.com_b != tcw_pkg::TCW_COM_NONE) |-> (pin_b_o.val == st_ff.oc_b))
    else $error("pin B not driven by compare output");
  AST_PORT_A: assert property (
    (st_ff.com_a == tcw_pkg::TCW_COM_NONE) |-> (pin_a_o.val == st_ff.port[tcw_pkg::TCW_PORT_DATA_A]))
    else $error("pin A not driven by port data");
  AST_PORT_B: assert property (
    (st_ff.com_b == tcw_pkg::TCW_COM_NONE) |-> (pin_b_o.val == st_ff.port[tcw_pkg::TCW_PORT_DATA_B]))
    else $error("pin B not driven by port data");
  AST_DIR_B: assert property (
    pin_b_o.oe == st_ff.port[tcw_pkg::TCW_PORT_DIR_B])
    else $error("pin B direction not from port");
  AST_HOLD_B: assert property (
    (tick_i && !wr && st_ff.com_b == tcw_pkg::TCW_COM_NONE) |=> $stable(st_ff.oc_b))
    else $error("compare output B changed with action zero");
  AST_ACTION_WAIT: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_CTRL && !tick_i)
    |=> ($stable(st_ff.oc_a) && $stable(st_ff.oc_b)))
    else $error("action write changed compare output at once");
  AST_FORCE_APPLY: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_FORCE && wbyte[0] && !pwm
      && st_ff.com_a == tcw_pkg::TCW_COM_SET) |=> st_ff.oc_a)
    else $error("force did not apply action to output A");
  AST_FORCE_PWM: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_FORCE && pwm && !tick_i)
    |=> ($stable(st_ff.oc_a) && $stable(st_ff.oc_b)))
    else $error("force acted in a PWM mode");
  AST_COUNT_UP: assert property (
    (tick_i && !wr && !pwm && st_ff.wgm != tcw_pkg::TCW_WGM_CTC)
    |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("counter did not step up by one");
  AST_COUNT_HOLD: assert property (
    (!tick_i && !cnt_wr) |=> $stable(st_ff.cnt))
    else $error("counter moved without a timer clock");
  AST_COUNT_WRITE: assert property (
    cnt_wr |=> st_ff.cnt == $past(wbyte))
    else $error("counter write not taken");
  AST_OVF_MAX: assert property (
    (tick_i && !pwm && st_ff.cnt == tcw_pkg::TCW_MAX) |=> st_ff.ovf)
    else $error("overflow flag not set at wrap");
  AST_OVF_STICKY: assert property (
    (st_ff.ovf && !(wr && wb_adr_i == tcw_pkg::TCW_OFF_FLAGS)) |=> st_ff.ovf)
    else $error("overflow flag cleared by counting");
  AST_CTC_COUNT: assert property (
    (tick_i && !wr && st_ff.wgm == tcw_pkg::TCW_WGM_CTC && !match_a)
    |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("clear-on-match count did not roll on");
  AST_CTC_TOGGLE: assert property (
    (tick_i && !wr && st_ff.wgm == tcw_pkg::TCW_WGM_CTC && match_a
      && st_ff.com_a == tcw_pkg::TCW_COM_TOGGLE) |=> st_ff.oc_a != $past(st_ff.oc_a))
    else $error("clear-on-match toggle did not toggle");
  AST_CTC_PERIOD: assert property (
    (tick_i && match_a && st_ff.gap_ok) |-> st_ff.gap == st_ff.cmp_a)
    else $error("clear-on-match period not one plus compare A");
  AST_FPWM_COUNT: assert property (
    (tick_i && !wr && pwm && !at_top)
    |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("fast PWM count did not step up");
  AST_FPWM7_TOP: assert property (
    (tick_i && !wr && st_ff.wgm == tcw_pkg::TCW_WGM_FPWM_CMPA && st_ff.cnt == st_ff.cmp_a)
    |=> st_ff.cnt == tcw_pkg::TCW_BOTTOM)
    else $error("fast PWM did not restart at compare A top");
  AST_FPWM_CLR: assert property (
    (tick_i && !wr && pwm && match_a && !at_top
      && st_ff.com_a == tcw_pkg::TCW_COM_CLEAR) |=> !st_ff.oc_a)
    else $error("fast PWM output not cleared at match");
  AST_FPWM_INV: assert property (
    (tick_i && !wr && pwm && at_top && st_ff.com_a == tcw_pkg::TCW_COM_SET)
    |=> !st_ff.oc_a)
    else $error("inverted fast PWM output not cleared at bottom");
  AST_FPWM_OVF: assert property (
    (tick_i && pwm && at_top) |=> st_ff.ovf)
    else $error("fast PWM overflow flag not set at top");
  AST_FPWM_EXTREME: assert property (
    (tick_i && !wr && pwm && at_top && match_a && st_ff.com_a[1])
    |=> st_ff.oc_a != st_ff.com_a[0])
    else $error("fast PWM level wrong with compare at top");
  AST_FPWM_TOGGLE: assert property (
    (tick_i && !wr && pwm && match_a && st_ff.com_a == tcw_pkg::TCW_COM_TOGGLE)
    |=> st_ff.oc_a != $past(st_ff.oc_a))
    else $error("fast PWM toggle did not toggle");
  AST_CMP_BYPASS: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_CMPA && !pwm) |=> st_ff.cmp_a == $past(wbyte))
    else $error("compare A write did not reach comparator");
  AST_CMP_BUFFER: assert property (
    (wr && wb_adr_i == tcw_pkg::TCW_OFF_CMPA && pwm && !(tick_i && at_top))
    |=> $stable(st_ff.cmp_a))
    else $error("buffered compare A changed before top");
  AST_FPWM_RELOAD: assert property (
    (tick_i && !wr && pwm && at_top) |=> st_ff.cmp_a == $past(st_ff.buf_a))
    else $error("compare A buffer not loaded at top");

  COV_CTC_TOGGLE: cover property (
    tick_i && st_ff.wgm == tcw_pkg::TCW_WGM_CTC && match_a && st_ff.com_a == tcw_pkg::TCW_COM_TOGGLE);
  COV_FPWM_WRAP: cover property (tick_i && pwm && at_top && st_ff.com_a == tcw_pkg::TCW_COM_CLEAR);
  COV_FORCE: cover property (wr && wb_adr_i == tcw_pkg::TCW_OFF_FORCE && !pwm);
  COV_SET_CLEAR: cover property (tick_i && st_ff.pend_a && wr && wb_adr_i == tcw_pkg::TCW_OFF_FLAGS);
  COV_FPWM_EXTREME: cover property (tick_i && pwm && at_top && match_a);

endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the timer compare/waveform unit.
// Assumes the unit's Wishbone classic port and a bench-driven tick_i.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTRL = tcw_pkg::TCW_OFF_CTRL;
  localparam logic [7:0] A_FRC = tcw_pkg::TCW_OFF_FORCE;
  localparam logic [7:0] A_CNT = tcw_pkg::TCW_OFF_COUNT;
  localparam logic [7:0] A_CMPA = tcw_pkg::TCW_OFF_CMPA;
  localparam logic [7:0] A_CMPB = tcw_pkg::TCW_OFF_CMPB;
  localparam logic [7:0] A_FLG = tcw_pkg::TCW_OFF_FLAGS;
  localparam logic [7:0] A_PORT = tcw_pkg::TCW_OFF_PORT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tick_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  tcw_pkg::tcw_pin_t pin_a_o;
  tcw_pkg::tcw_pin_t pin_b_o;
  logic [31:0] rd;
  int err_total = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  tcw_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_a_o(pin_a_o),
    .pin_b_o(pin_b_o));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Entered just after a rising edge; ack is read before that edge's updates land
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
    wb_cycle(1'b0, adr, 8'h00);
    check(what, rd, {24'h0, exp});
  endtask

  // Extra edge at the end lets the last tick's pin update settle
  task automatic ticks(input int n);
    tick_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    tick_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pin_chk(input string what, input logic [1:0] exp);
    check(what, {30'h0, pin_a_o.val, pin_a_o.oe}, {30'h0, exp});
  endtask

  task automatic pinb_chk(input string what, input logic [1:0] exp);
    check(what, {30'h0, pin_b_o.val, pin_b_o.oe}, {30'h0, exp});
  endtask

  task automatic test_reset();
    rd_chk("ctrl", A_CTRL, 8'h00);
    rd_chk("count", A_CNT, 8'h00);
    rd_chk("flags", A_FLG, 8'h00);
    rd_chk("unmapped", 8'h40, 8'h00);
    pin_chk("pin a idle", 2'b00);
    $display("test_reset done");
  endtask

  // Match at the written count is blocked; B matches one count later
  task automatic test_normal();
    wr(A_CMPA, 8'hfd);
    wr(A_CMPB, 8'hfe);
    wr(A_CNT, 8'hfd);
    ticks(3);
    rd_chk("count wrap", A_CNT, 8'h00);
    rd_chk("flags normal", A_FLG, 8'h05);
    wr(A_FLG, 8'h07);
    rd_chk("flags cleared", A_FLG, 8'h00);
    $display("test_normal done");
  endtask

  task automatic test_force();
    wr(A_PORT, 8'h05);
    pin_chk("port drives", 2'b11);
    wr(A_CTRL, 8'h20);
    wr(A_FRC, 8'h01);
    pin_chk("force clear", 2'b01);
    wr(A_CTRL, 8'h30);
    wr(A_FRC, 8'h01);
    pin_chk("force set", 2'b11);
    wr(A_PORT, 8'h04);
    wr(A_CTRL, 8'h00);
    pin_chk("action off", 2'b01);
    wr(A_CTRL, 8'h30);
    pin_chk("state kept", 2'b11);
    rd_chk("force no flag", A_FLG, 8'h00);
    rd_chk("force no count", A_CNT, 8'h00);
    wr(A_PORT, 8'h00);
    pin_chk("dir input", 2'b10);
    wr(A_PORT, 8'h0c);
    pinb_chk("port drives b", 2'b01);
    wr(A_CTRL, 8'hf0);
    wr(A_FRC, 8'h02);
    pinb_chk("force set b", 2'b11);
    wr(A_PORT, 8'h04);
    pinb_chk("dir input b", 2'b10);
    $display("test_force done");
  endtask

  // Toggle every third tick with compare A at 2
  task automatic test_ctc();
    wr(A_CTRL, 8'h12);
    wr(A_CMPA, 8'h02);
    wr(A_CNT, 8'h00);
    ticks(3);
    pin_chk("ctc toggle 1", 2'b01);
    ticks(2);
    pin_chk("ctc hold", 2'b01);
    ticks(1);
    pin_chk("ctc toggle 2", 2'b11);
    rd_chk("ctc count", A_CNT, 8'h00);
    rd_chk("ctc flags", A_FLG, 8'h02);
    wr(A_FLG, 8'h07);
    $display("test_ctc done");
  endtask

  // Inverted PWM: cleared at bottom, set at the buffered compare value
  task automatic test_pwm();
    wr(A_CTRL, 8'h33);
    wr(A_CMPA, 8'h04);
    rd_chk("cmpa buffer", A_CMPA, 8'h04);
    wr(A_CNT, 8'hfe);
    ticks(2);
    pin_chk("pwm bottom", 2'b01);
    rd_chk("pwm restart", A_CNT, 8'h00);
    ticks(4);
    pin_chk("pwm before match", 2'b01);
    ticks(1);
    pin_chk("pwm match", 2'b11);
    rd_chk("pwm flags", A_FLG, 8'h03);
    $display("test_pwm done");
  endtask

  // Compare A as top in mode 7, toggling; the new top loads at the first wrap
  task automatic test_pwm_top();
    wr(A_CTRL, 8'h17);
    wr(A_CMPA, 8'h02);
    wr(A_CNT, 8'h03);
    ticks(2);
    pin_chk("top toggle", 2'b01);
    rd_chk("top restart", A_CNT, 8'h00);
    ticks(3);
    pin_chk("new top toggle", 2'b11);
    rd_chk("new top restart", A_CNT, 8'h00);
    $display("test_pwm_top done");
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_normal();
    test_force();
    test_ctc();
    test_pwm();
    test_pwm_top();
    print_verdict();
  end
endmodule
